// [lcd_key_pkg.sv]
// shared constants for the lcd key serial port, and the display memory
// Notes on behaviour
// - select low enables port; high ignores it
// - internal state reachable only while selected
// - write bits captured on shift clock rise
// - read bits change on shift clock fall
// - drive data pin from read command to deselect
// - data pin stays input outside reads
// - reset forces data pin to input
// - high bit means lit, high, pressed
// - reset sets defined initial state; the display memory is not reset and holds unknown dots
// - one memory bit per panel dot
// - 80 segments, 18 commons, count programmable
// - key matrix scanned without host help
// - ready rises after two cycles, falls released
// - rows driven low singly, ascending order
package lcd_key_pkg;
  // system clock rate and scan timing
  localparam int unsigned SYS_MHZ = 40;
  localparam int unsigned KEY_ROW_NS = 100000;
  localparam int unsigned KEY_ROW_CYCLES = (KEY_ROW_NS * SYS_MHZ) / 1000;
  localparam int unsigned COM_NS = 100000;
  localparam int unsigned COM_CYCLES = (COM_NS * SYS_MHZ) / 1000;
  // panel and key matrix geometry
  localparam int SEG_COUNT = 80;
  localparam int COM_COUNT = 18;
  localparam int LANE_COUNT = 10;
  localparam int KEY_ROWS = 5;
  localparam int KEY_COLS = 5;
  localparam int HOLD_BITS = 40;
  // reset values
  localparam logic [4:0] COMMONS_RESET = 5'h12;
  localparam logic [4:0] ROW_DRIVE_RESET = 5'h1E;
  localparam logic [2:0] KEY_ROW_RESET = 3'h0;
  // command opcodes, top three bits of the first byte
  localparam logic [2:0] OP_RAM_WRITE = 3'h1;
  localparam logic [2:0] OP_RAM_READ = 3'h2;
  localparam logic [2:0] OP_KEY_READ = 3'h3;
  localparam logic [2:0] OP_SET_COMMONS = 3'h4;
  localparam logic [2:0] OP_PORT_WRITE = 3'h5;
  // read framing: dummy bits then payload
  localparam logic [5:0] DUMMY_BITS = 6'h08;
  localparam logic [5:0] READ_END_BITS = 6'h30;
  localparam logic [1:0] PRESS_CYCLES = 2'h2;

  // number of bytes that complete a command
  function automatic logic [2:0] frame_bytes(input logic [2:0] op);
    logic [2:0] n;
    n = 3'h1;
    if (op == OP_RAM_WRITE) begin
      n = 3'h3;
    end else if (op == OP_RAM_READ || op == OP_PORT_WRITE) begin
      n = 3'h2;
    end
    return n;
  endfunction
endpackage

// bit-mapped display memory, one row per common, registered read
module display_ram (
  // clock
  input wire logic clock_i,
  // byte write port
  input wire logic wr_en_i,
  input wire logic [4:0] wr_row_i,
  input wire logic [3:0] wr_lane_i,
  input wire logic [7:0] wr_data_i,
  // row read port, caller keeps rows in range
  input wire logic [4:0] rd_row_i,
  output logic [lcd_key_pkg::SEG_COUNT-1:0] rd_data_o
);
  logic [lcd_key_pkg::SEG_COUNT-1:0] mem [0:lcd_key_pkg::COM_COUNT-1];

  // one bit per dot, a byte lane per write
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_row_i][wr_lane_i*8 +: 8] <= wr_data_i;
    end
    rd_data_o <= mem[rd_row_i];
  end
endmodule // display_ram

// [lcd_key_serial_host_port.sv]
// serial host port, key scanner and panel refresh of the lcd driver
module lcd_key_serial_host_port (
  // system clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // host serial link
  input wire logic shift_clock_in_i,
  input wire logic cs_n_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_n_o,
  output logic key_ready_flag_o,
  // key matrix
  output logic [4:0] scan_row_drive_n_o,
  input wire logic [4:0] scan_col_sense_n_i,
  // panel and general ports
  output logic [lcd_key_pkg::SEG_COUNT-1:0] segment_drive_o,
  output logic [lcd_key_pkg::COM_COUNT-1:0] common_drive_o,
  output logic led_port_out_o,
  output logic [7:0] aux_port_out_o
);
  // link domain, clocked by the host shift clock
  logic link_rst, done, reading, req_toggle;
  logic [2:0] bit_cnt, byte_cnt, op, req_op;
  logic [6:0] shift_in;
  logic [4:0] arg, req_arg;
  logic [7:0] b1, req_b1, req_b2;
  logic [5:0] rd_cnt;
  wire [7:0] new_byte = {shift_in, serial_data_i};
  wire byte_end = (bit_cnt == 3'h7) && !done;
  wire [2:0] op_now = (byte_cnt == 3'h0) ? new_byte[7:5] : op;
  wire issue = byte_end &&
    (byte_cnt + 3'h1 == lcd_key_pkg::frame_bytes(op_now));
  wire is_read = (op_now == lcd_key_pkg::OP_RAM_READ) ||
    (op_now == lcd_key_pkg::OP_KEY_READ);
  logic [lcd_key_pkg::HOLD_BITS-1:0] hold;
  wire [5:0] out_idx = 6'(6'h2F - rd_cnt);
  wire next_sdo = (rd_cnt >= lcd_key_pkg::DUMMY_BITS) &&
    (rd_cnt < lcd_key_pkg::READ_END_BITS) && hold[out_idx];

  // deselect ends the frame, so no stopped-clock edge is needed
  assign link_rst = rst_i | cs_n_i;

  // shift in on rising edges
  always_ff @(posedge shift_clock_in_i or posedge link_rst) begin
    if (link_rst) begin
      {bit_cnt, byte_cnt, shift_in} <= 13'h0000;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= new_byte[6:0];
      byte_cnt <= byte_end ? byte_cnt + 3'h1 : byte_cnt;
    end
  end

  // command fields and read state; bytes after the frame are ignored
  always_ff @(posedge shift_clock_in_i or posedge link_rst) begin
    if (link_rst) begin
      {op, arg, b1, done, reading} <= 18'h00000;
    end else if (byte_end) begin
      if (byte_cnt == 3'h0) begin
        op <= new_byte[7:5];
        arg <= new_byte[4:0];
      end
      if (byte_cnt == 3'h1) begin
        b1 <= new_byte;
      end
      if (issue) begin
        done <= 1'b1;
        reading <= is_read;
      end
    end
  end

  // request word and toggle survive deselect so the parity stays true
  always_ff @(posedge shift_clock_in_i or posedge rst_i) begin
    if (rst_i) begin
      {req_toggle, req_op, req_arg, req_b1, req_b2} <= 25'h0000000;
    end else if (issue) begin
      req_toggle <= ~req_toggle;
      req_op <= op_now;
      req_arg <= (byte_cnt == 3'h0) ? new_byte[4:0] : arg;
      req_b1 <= (byte_cnt == 3'h1) ? new_byte : b1;
      req_b2 <= new_byte;
    end
  end

  // drive out on falling edges, dummy byte first, then payload msb first
  always_ff @(negedge shift_clock_in_i or posedge link_rst) begin
    if (link_rst) begin
      serial_data_oe_n_o <= 1'b1;
      serial_data_o <= 1'b0;
      rd_cnt <= 6'h00;
    end else if (reading) begin
      serial_data_oe_n_o <= 1'b0;
      serial_data_o <= next_sdo;
      if (rd_cnt != 6'h3F) begin
        rd_cnt <= rd_cnt + 6'h01;
      end
    end
  end

  // system domain
  logic tg1, tg2, tg3, tg_seen;
  logic [4:0] c1, c2, c3, col_stable;
  logic req_event, host_rd, host_rd_d;
  logic [4:0] active_commons, com_idx, last_row;
  localparam logic [lcd_key_pkg::COM_COUNT-1:0] COMMON_ONE = 18'h00001;
  logic [12:0] com_cnt;
  logic [11:0] row_cnt;
  logic [2:0] key_row;
  logic [24:0] keys_work, key_state;
  logic [1:0] press_cnt;
  logic [lcd_key_pkg::SEG_COUNT-1:0] ram_q;
  wire tg_agree = (tg2 == tg3);
  wire row_end = (row_cnt == 12'(lcd_key_pkg::KEY_ROW_CYCLES - 1));
  wire com_end = (com_cnt == 13'(lcd_key_pkg::COM_CYCLES - 1));
  wire cycle_end = row_end && (key_row == 3'h4);
  // concatenation keeps the upper bits zero before the shift
  wire [24:0] next_keys = keys_work |
    ({20'h00000, ~col_stable} << (key_row * 5));
  wire any_key = |next_keys;
  wire row_ok = req_arg < 5'(lcd_key_pkg::COM_COUNT);
  wire lane_ok = req_b1 < 8'(lcd_key_pkg::LANE_COUNT);
  // a bad lane would index past the row, so it is refused like a bad row
  wire addr_ok = row_ok && lane_ok;
  wire ram_we = req_event && (req_op == lcd_key_pkg::OP_RAM_WRITE) &&
    addr_ok;
  wire [4:0] rd_row = host_rd ? req_arg : com_idx;
  wire [2:0] next_row = (key_row == 3'h4) ? 3'h0 : key_row + 3'h1;
  wire [4:0] next_com = (com_idx + 5'h01 >= active_commons) ? 5'h00 :
    com_idx + 5'h01;

  // three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      {tg1, tg2, tg3, tg_seen} <= 4'h0;
      {c1, c2, c3, col_stable} <= 20'hFFFFF; // open keys read high
    end else begin
      tg1 <= req_toggle;
      tg2 <= tg1;
      tg3 <= tg2;
      tg_seen <= tg_agree ? tg3 : tg_seen;
      c1 <= scan_col_sense_n_i;
      c2 <= c1;
      c3 <= c2;
      col_stable <= (c3 & ~(c2 ^ c3)) | (col_stable & (c2 ^ c3));
    end
  end

  assign req_event = tg_agree && (tg3 != tg_seen);

  // command execution; reads park their answer in hold for the link
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      host_rd <= 1'b0;
      host_rd_d <= 1'b0;
      hold <= '0;
      active_commons <= lcd_key_pkg::COMMONS_RESET;
      led_port_out_o <= 1'b0;
      aux_port_out_o <= 8'h00;
    end else begin
      host_rd <= req_event && (req_op == lcd_key_pkg::OP_RAM_READ) && addr_ok;
      host_rd_d <= host_rd;
      if (host_rd_d) begin
        hold <= {ram_q[req_b1[3:0]*8 +: 8], 32'h0};
      end
      if (req_event && req_op == lcd_key_pkg::OP_RAM_READ && !addr_ok) begin
        hold <= '0;
      end
      if (req_event && req_op == lcd_key_pkg::OP_KEY_READ) begin
        // pressed keys read high, one row per byte
        hold <= {3'h0, key_state[4:0], 3'h0, key_state[9:5],
          3'h0, key_state[14:10], 3'h0, key_state[19:15],
          3'h0, key_state[24:20]};
      end
      if (req_event && req_op == lcd_key_pkg::OP_SET_COMMONS &&
          req_arg != 5'h00 && req_arg <= 5'(lcd_key_pkg::COM_COUNT)) begin
        active_commons <= req_arg;
      end
      if (req_event && req_op == lcd_key_pkg::OP_PORT_WRITE) begin
        led_port_out_o <= req_arg[0];
        aux_port_out_o <= req_b2;
      end
    end
  end

  display_ram ram (
    .clock_i(clock_i),
    .wr_en_i(ram_we),
    .wr_row_i(req_arg),
    .wr_lane_i(req_b1[3:0]),
    .wr_data_i(req_b2),
    .rd_row_i(rd_row),
    .rd_data_o(ram_q)
  );

  // panel refresh; a host read steals one slot, the old row simply holds
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      com_cnt <= 13'h0000;
      com_idx <= 5'h00;
      last_row <= 5'h00;
      segment_drive_o <= '0;
      common_drive_o <= '0;
    end else begin
      com_cnt <= com_end ? 13'h0000 : com_cnt + 13'h0001;
      com_idx <= com_end ? next_com : com_idx;
      last_row <= host_rd ? last_row : com_idx;
      if (!host_rd_d) begin
        segment_drive_o <= ram_q;
        common_drive_o <= COMMON_ONE << last_row;
      end
    end
  end

  // autonomous scan, one row low at a time in ascending order
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      row_cnt <= 12'h000;
      key_row <= lcd_key_pkg::KEY_ROW_RESET;
      scan_row_drive_n_o <= lcd_key_pkg::ROW_DRIVE_RESET;
      keys_work <= 25'h0000000;
      key_state <= 25'h0000000;
    end else begin
      row_cnt <= row_end ? 12'h000 : row_cnt + 12'h001;
      if (row_end) begin
        key_row <= next_row;
        scan_row_drive_n_o <= ~(5'h01 << next_row);
        keys_work <= cycle_end ? 25'h0000000 : next_keys;
        if (cycle_end) begin
          key_state <= next_keys;
        end
      end
    end
  end

  // ready after two whole cycles with a key down, low once all open
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      press_cnt <= 2'h0;
      key_ready_flag_o <= 1'b0;
    end else if (cycle_end) begin
      if (!any_key) begin
        press_cnt <= 2'h0;
        key_ready_flag_o <= 1'b0;
      end else if (press_cnt != lcd_key_pkg::PRESS_CYCLES) begin
        press_cnt <= press_cnt + 2'h1;
        key_ready_flag_o <= (press_cnt + 2'h1 == lcd_key_pkg::PRESS_CYCLES);
      end
    end
  end

  // checks on both domains
  property p_idle_input;
    @(posedge clock_i) disable iff (rst_i)
      cs_n_i && $past(cs_n_i) |-> serial_data_oe_n_o;
  endproperty
  a_idle_input: assert property (p_idle_input)
    else $error("data pin driven while deselected");

  property p_reset_input;
    @(posedge clock_i) disable iff (rst_i)
      $fell(rst_i) |-> serial_data_oe_n_o && !key_ready_flag_o;
  endproperty
  a_reset_input: assert property (p_reset_input)
    else $error("data pin or ready not idle after reset");

  property p_drive_only_reading;
    @(posedge shift_clock_in_i) disable iff (link_rst)
      !serial_data_oe_n_o |-> reading && done;
  endproperty
  a_drive_only_reading: assert property (p_drive_only_reading)
    else $error("data pin driven without a read command");

  property p_dummy_low;
    @(posedge shift_clock_in_i) disable iff (link_rst)
      !serial_data_oe_n_o && rd_cnt <= 6'h08 |-> !serial_data_o;
  endproperty
  a_dummy_low: assert property (p_dummy_low)
    else $error("dummy read bits not low");

  property p_drive_starts;
    @(posedge shift_clock_in_i) disable iff (link_rst)
      issue && is_read |-> ##1 !serial_data_oe_n_o;
  endproperty
  a_drive_starts: assert property (p_drive_starts)
    else $error("read command did not turn the data pin");

  property p_one_row;
    @(posedge clock_i) disable iff (rst_i)
      $onehot(~scan_row_drive_n_o);
  endproperty
  a_one_row: assert property (p_one_row)
    else $error("more or fewer than one scan row low");

  property p_row_order;
    @(posedge clock_i) disable iff (rst_i)
      $changed(scan_row_drive_n_o) |->
        ~scan_row_drive_n_o == {~$past(scan_row_drive_n_o[3:0]),
          ~$past(scan_row_drive_n_o[4])};
  endproperty
  a_row_order: assert property (p_row_order)
    else $error("scan rows out of ascending order");

  property p_ready_rise;
    @(posedge clock_i) disable iff (rst_i)
      $rose(key_ready_flag_o) |-> $past(cycle_end) && $past(any_key) &&
        $past(press_cnt) == 2'h1;
  endproperty
  a_ready_rise: assert property (p_ready_rise)
    else $error("key ready rose without two pressed cycles");

  property p_ready_fall;
    @(posedge clock_i) disable iff (rst_i)
      cycle_end && !any_key |=> !key_ready_flag_o ##1 !key_ready_flag_o;
  endproperty
  a_ready_fall: assert property (p_ready_fall)
    else $error("key ready stayed high with all keys open");

  property p_port_write;
    @(posedge clock_i) disable iff (rst_i)
      req_event && req_op == lcd_key_pkg::OP_PORT_WRITE |=>
        led_port_out_o == $past(req_arg[0]) &&
        aux_port_out_o == $past(req_b2);
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("port write not applied");

  property p_common_range;
    @(posedge clock_i) disable iff (rst_i)
      $onehot0(common_drive_o) &&
        (!$past(com_end) || com_idx < $past(active_commons));
  endproperty
  a_common_range: assert property (p_common_range)
    else $error("common scan outside active count");
endmodule // lcd_key_serial_host_port

// [lcd_host_model.sv]
// host cpu model that runs select, shift clock and the shared data line
module lcd_host_model (
  // line level and device drive state
  input wire logic line_i,
  input wire logic oe_n_i,
  // link outputs of the host
  output logic shift_clock_o,
  output logic cs_n_o,
  output logic data_o,
  output logic drive_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 24;

  // shift clock stands low outside frames
  initial begin
    shift_clock_o = 1'b0;
    cs_n_o = 1'b1;
    data_o = 1'b0;
    drive_o = 1'b0;
  end

  // one frame, msb first; sel low leaves the device deselected
  task automatic frame(input logic sel, input logic [23:0] tx, input int nb,
                       input int nrx, output logic [47:0] rx,
                       output logic oe_last);
    rx = '0;
    oe_last = 1'b1;
    #7;
    cs_n_o = !sel;
    #(HALF);
    for (int i = 0; i < nb; i++) begin
      data_o = tx[nb-1-i];
      drive_o = 1'b1;
      #(HALF);
      shift_clock_o = 1'b1;
      oe_last = oe_n_i;
      #4;
      // let go before the device's first falling-edge drive
      if (i == nb - 1 && nrx > 0) begin
        drive_o = 1'b0;
      end
      #(HALF - 4);
      shift_clock_o = 1'b0;
    end
    for (int j = 0; j < nrx; j++) begin
      #(HALF);
      shift_clock_o = 1'b1;
      rx = {rx[46:0], line_i};
      oe_last = oe_n_i;
      #(HALF);
      shift_clock_o = 1'b0;
    end
    #(HALF);
    drive_o = 1'b0;
    cs_n_o = 1'b1;
    // spacing keeps commands well apart in system time
    #200;
  endtask
endmodule // lcd_host_model

// [lcd_key_serial_host_port_tb.sv]
// self-checking bench for the lcd key serial host port
module lcd_key_serial_host_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SCAN = lcd_key_pkg::KEY_ROW_CYCLES * lcd_key_pkg::KEY_ROWS;
  localparam int COMS = lcd_key_pkg::COM_CYCLES;
  logic clock_i, rst_i, sck, cs_n, hd, drive, sdo, oe_n, ready, led;
  logic last_lvl, line, key_on, oe_last;
  logic [4:0] rows, cols, prev_rows;
  logic [2:0] key_row, key_col;
  logic [lcd_key_pkg::SEG_COUNT-1:0] segs;
  logic [lcd_key_pkg::COM_COUNT-1:0] coms;
  logic [7:0] aux;
  logic [47:0] rx;
  int n_mismatch = 0;
  int total_checks = 0;

  lcd_key_serial_host_port lcd_key_serial_host_port_i (
    .clock_i(clock_i), .rst_i(rst_i), .shift_clock_in_i(sck),
    .cs_n_i(cs_n), .serial_data_i(line), .serial_data_o(sdo),
    .serial_data_oe_n_o(oe_n), .key_ready_flag_o(ready),
    .scan_row_drive_n_o(rows), .scan_col_sense_n_i(cols),
    .segment_drive_o(segs), .common_drive_o(coms), .led_port_out_o(led),
    .aux_port_out_o(aux));

  lcd_host_model lcd_host_model_i (
    .line_i(line), .oe_n_i(oe_n), .shift_clock_o(sck), .cs_n_o(cs_n),
    .data_o(hd), .drive_o(drive));

  // undriven line shows the inverse of its last level, no pull on it
  assign line = (oe_n === 1'b0) ? sdo : (drive ? hd : ~last_lvl);

  // remember the last driven level
  always @(posedge clock_i) begin
    if (oe_n === 1'b0 || drive) last_lvl <= line;
  end

  // one pressed key in the matrix pulls its column low on its row
  always @(posedge clock_i) begin
    cols <= (key_on && rows[key_row] === 1'b0) ? ~(5'h01 << key_col) : 5'h1F;
  end

  // every row change must step to the next row, wrapping 4 to 0
  always @(posedge clock_i) begin
    if (rst_i) begin
      prev_rows <= lcd_key_pkg::ROW_DRIVE_RESET;
    end else if (rows !== prev_rows) begin
      check(rows, {prev_rows[3:0], prev_rows[4]}, "row order");
      prev_rows <= rows;
    end
  end

  // system clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic check(input logic [47:0] act, input logic [47:0] exp,
                       input string what);
    total_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset;
    check(oe_n, 1'b1, "oe after reset");
    check({ready, led, aux, rows}, {1'b0, 1'b0, 8'h00, 5'h1E}, "reset");
    check(coms, '0, "commons after reset");
  endtask

  task automatic t_deselect;
    lcd_host_model_i.frame(1'b0, {lcd_key_pkg::OP_PORT_WRITE, 5'h01, 8'hFF},
                           16, 0, rx, oe_last);
    repeat (20) @(posedge clock_i);
    check({led, aux}, 9'h000, "deselected write");
  endtask

  task automatic t_port;
    lcd_host_model_i.frame(1'b1, {lcd_key_pkg::OP_PORT_WRITE, 5'h01, 8'h5A},
                           16, 0, rx, oe_last);
    repeat (20) @(posedge clock_i);
    check({led, aux}, 9'h15A, "port write");
    check(oe_last, 1'b1, "oe on write");
  endtask

  task automatic t_ram;
    lcd_host_model_i.frame(1'b1, {lcd_key_pkg::OP_RAM_WRITE, 5'h01, 8'h02,
                           8'hC5}, 24, 0, rx, oe_last);
    check(oe_last, 1'b1, "oe on ram write");
    lcd_host_model_i.frame(1'b1, {lcd_key_pkg::OP_RAM_READ, 5'h01, 8'h02},
                           16, 16, rx, oe_last);
    check(rx[15:0], 16'h00C5, "ram read");
    check(oe_last, 1'b0, "oe during read");
    check(oe_n, 1'b1, "oe after deselect");
    lcd_host_model_i.frame(1'b1, {lcd_key_pkg::OP_RAM_READ, 5'h14, 8'h02},
                           16, 16, rx, oe_last);
    check(rx[15:0], 16'h0000, "bad row read");
  endtask

  task automatic t_commons;
    int n;
    lcd_host_model_i.frame(1'b1, {lcd_key_pkg::OP_SET_COMMONS, 5'h02},
                           8, 0, rx, oe_last);
    for (n = 0; n < 3 * COMS && coms !== 18'h00002; n++) @(posedge clock_i);
    repeat (10) @(posedge clock_i);
    check(coms, 18'h00002, "common 1 active");
    check(segs[23:16], 8'hC5, "row 1 lane 2 dots");
    for (n = 0; n < COMS + 20 && coms === 18'h00002; n++) @(posedge clock_i);
    check(coms, 18'h00001, "wrap at two commons");
  endtask

  task automatic t_key;
    int n;
    for (n = 0; n < SCAN && rows !== 5'h0F; n++) @(posedge clock_i);
    for (n = 0; n < SCAN && rows !== 5'h1E; n++) @(posedge clock_i);
    key_on <= 1'b1;
    repeat (SCAN + SCAN / 2) @(posedge clock_i);
    check(ready, 1'b0, "ready too early");
    for (n = 0; n < SCAN / 2 + 300 && ready !== 1'b1; n++) @(posedge clock_i);
    check(ready, 1'b1, "ready after two scans");
    lcd_host_model_i.frame(1'b1, {lcd_key_pkg::OP_KEY_READ, 5'h00},
                           8, 48, rx, oe_last);
    check(rx, 48'h0000_0002_0000, "key read");
    check(oe_last, 1'b0, "oe during key read");
    key_on <= 1'b0;
    for (n = 0; n < SCAN + 300 && ready !== 1'b0; n++) @(posedge clock_i);
    check(ready, 1'b0, "ready after release");
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    key_on = 1'b0;
    key_row = 3'h2;
    key_col = 3'h1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_reset();
    t_deselect();
    t_port();
    t_ram();
    t_commons();
    t_key();
    end_sim();
  end

  // watchdog sized above the key scan waits
  initial begin
    repeat (100000) @(posedge clock_i);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule // lcd_key_serial_host_port_tb
